/* rtl/vsa_defines.svh */
// offsets, field positions, reset values and counts of the signature analyzer
`ifndef VSA_DEFINES_SVH
`define VSA_DEFINES_SVH

`define VSA_ADDR_RESULT 32'h8003_0200
`define VSA_ADDR_CTRL 32'h8003_0204
`define VSA_ADDR_VWIN 32'h8003_0208
`define VSA_ADDR_HWIN 32'h8003_020C
`define VSA_ADDR_CLRPT 32'h8003_0210
`define VSA_ADDR_STATUS 32'h8003_0214
`define VSA_ADDR_MASK 32'h8003_0218

`define VSA_RESET_WORD 32'h0000_0000
`define VSA_RESET_SIG 16'h0000

`define VSA_CTRL_EN 31
`define VSA_CTRL_PIXEL_CLOCK_OUT_SELECT 29
`define VSA_CTRL_BRIGHTNESS_OUT_SELECT 28
`define VSA_CTRL_CLOCK_GATE_OUT_SELECT 27
`define VSA_CTRL_BLANK 26
`define VSA_CTRL_HSYNC 25
`define VSA_CTRL_VSYNC 24
`define VSA_CTRL_MASK 32'hBFFF_FFFF

`define VSA_PEN_W 24
`define VSA_CNT_W 12
`define VSA_LO_LSB 0
`define VSA_HI_LSB 16
`define VSA_WIN_MASK 32'h0FFF_0FFF

`define VSA_IRQ_CLEAR 0
`define VSA_IRQ_STORE 1
`define VSA_STAT_MASK 32'h0000_0003

`define VSA_SIG_W 16
`define VSA_SIG_TAPS 16'hB400
`define VSA_DATA_W 30

`define VSA_FRAME_W 4
`define VSA_GRAY_LAST 4'hB
`define VSA_FRAME_ZERO 4'h0
`define VSA_FRAME_ONE 4'h1

`endif

/* rtl/vsa_lfsr.sv */
// multiple-input signature shift register
`timescale 1ns/1ps
module vsa_lfsr (
  input wire logic clock_i,
  input wire logic resetn_i,
  vsa_sig_if.engine sig
);
  import vsa_pkg::*;

  vsa_lfsr_state_type st;
  vsa_lfsr_state_type next_st;

  // wide input folded onto the register width, bit i onto bit i mod width
  function automatic vsa_sig_type fold(input vsa_data_type d);
    vsa_sig_type f;
    f = '0;
    for (int i = 0; i < `VSA_DATA_W; i++) begin
      f[i % `VSA_SIG_W] = f[i % `VSA_SIG_W] ^ d[i];
    end
    return f;
  endfunction

  always_comb begin
    next_st = st;
    if (sig.clear) begin
      // clear wins over a sample taken in the same cycle
      next_st.lfsr = `VSA_RESET_SIG;
    end else if (sig.accumulate) begin
      next_st.lfsr = {st.lfsr[`VSA_SIG_W-2:0], ^(st.lfsr & `VSA_SIG_TAPS)} ^ fold(sig.data);
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sig.signature = st.lfsr;
endmodule

/* rtl/vsa_pkg.sv */
// types shared by the signature analyzer modules
package vsa_pkg;
  `include "vsa_defines.svh"

  typedef logic [31:0] vsa_word_type;
  typedef logic [`VSA_SIG_W-1:0] vsa_sig_type;
  typedef logic [`VSA_CNT_W-1:0] vsa_count_type;
  typedef logic [`VSA_PEN_W-1:0] vsa_pixel_type;
  typedef logic [`VSA_DATA_W-1:0] vsa_data_type;

  typedef struct packed {
    vsa_word_type ctrl;
    vsa_word_type vwin;
    vsa_word_type hwin;
    vsa_word_type clrpt;
    vsa_word_type status;
    vsa_word_type mask;
    vsa_word_type rdata;
    vsa_sig_type result;
    logic vact;
    logic hact;
    logic cmatch;
    logic store_pulse;
    logic [`VSA_FRAME_W-1:0] frame;
  } vsa_state_type;

  typedef struct packed {
    vsa_sig_type lfsr;
  } vsa_lfsr_state_type;
endpackage

/* rtl/vsa_sig_if.sv */
// link between the analyzer core and its shift register
`timescale 1ns/1ps
interface vsa_sig_if;
  import vsa_pkg::*;
  logic accumulate;
  logic clear;
  vsa_data_type data;
  vsa_sig_type signature;

  modport core (output accumulate, output clear, output data, input signature);
  modport engine (input accumulate, input clear, input data, output signature);
endinterface

/* rtl/vsa_top.sv */
// video output signature analyzer with its register file
//
// Behaviour
// - control bit 31 switches the shift register on so it accumulates selected signals.
// - control bits 29 to 24 each admit one video control output into the signature.
// - the per-bit pixel select field picks which pixel bits feed the signature.
// - the vertical window turns on when the vertical down count equals its start value.
// - the vertical window turns off when the vertical down count equals its stop value.
// - the horizontal window turns on when the horizontal down count equals its start value.
// - the horizontal window turns off when the horizontal down count equals its stop value.
// - accumulation happens only while both windows are active.
// - the vertical clear point is the line whose down count equals the vertical clear value.
// - the horizontal clear point is the pixel whose down count equals the horizontal clear value.
// - both clear points together copy the signature into the result and clear the register.
// - the clear-and-store event also drives an edge-capable secondary raster interrupt.
// - the read-only result register holds the 16-bit signature, refreshed once per frame.
// - in grayscale operation the result updates only once every 12 frames.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module vsa_top (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire vsa_pkg::vsa_word_type addr_i,
  input wire vsa_pkg::vsa_word_type wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output vsa_pkg::vsa_word_type rdata_o,
  input wire vsa_pkg::vsa_pixel_type pixel_i,
  input wire logic pixel_clock_level_i,
  input wire logic brightness_i,
  input wire logic clock_gate_i,
  input wire logic blank_i,
  input wire logic hsync_i,
  input wire logic vsync_i,
  input wire vsa_pkg::vsa_count_type hcount_i,
  input wire vsa_pkg::vsa_count_type vcount_i,
  input wire logic grayscale_i,
  output logic clear_and_store_o,
  output logic irq_o
);
  import vsa_pkg::*;

  vsa_state_type st;
  vsa_state_type next_st;
  vsa_sig_if sig ();

  logic enable;
  logic vertical_clear_point;
  logic horizontal_clear_point;
  logic clear_and_store;
  logic store_ok;
  logic accumulate_enable;
  vsa_count_type vertical_start_count;
  vsa_count_type vertical_stop_count;
  vsa_count_type window_begin_count;
  vsa_count_type horizontal_stop_count;
  vsa_count_type vertical_clear_count;
  vsa_count_type horizontal_clear_count;
  vsa_pixel_type pixel_bit_select;
  logic [5:0] ctrl_select;

  function automatic vsa_count_type field_lo(input vsa_word_type w);
    return w[`VSA_LO_LSB +: `VSA_CNT_W];
  endfunction

  function automatic vsa_count_type field_hi(input vsa_word_type w);
    return w[`VSA_HI_LSB +: `VSA_CNT_W];
  endfunction

  assign enable = st.ctrl[`VSA_CTRL_EN];
  assign pixel_bit_select = st.ctrl[`VSA_PEN_W-1:0];
  assign ctrl_select = st.ctrl[`VSA_CTRL_PIXEL_CLOCK_OUT_SELECT:`VSA_CTRL_VSYNC];
  assign vertical_start_count = field_lo(st.vwin);
  assign vertical_stop_count = field_hi(st.vwin);
  assign window_begin_count = field_lo(st.hwin);
  assign horizontal_stop_count = field_hi(st.hwin);
  assign vertical_clear_count = field_hi(st.clrpt);
  assign horizontal_clear_count = field_lo(st.clrpt);

  assign vertical_clear_point = (vcount_i == vertical_clear_count);
  assign horizontal_clear_point = (hcount_i == horizontal_clear_count);
  // first cycle of the joint match only, and only when enabled
  assign clear_and_store = vertical_clear_point && horizontal_clear_point && !st.cmatch && enable;
  // one store in every 12 frames while grayscale
  assign store_ok = !grayscale_i || (st.frame == `VSA_FRAME_ZERO);
  assign accumulate_enable = st.vact && st.hact && enable;

  assign sig.accumulate = accumulate_enable;
  assign sig.clear = clear_and_store;
  // deselected inputs are forced to zero
  assign sig.data = {
    {pixel_clock_level_i, brightness_i, clock_gate_i, blank_i, hsync_i, vsync_i} & ctrl_select,
    pixel_i & pixel_bit_select
  };

  vsa_lfsr u_lfsr (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .sig(sig)
  );

  always_comb begin
    next_st = st;
    next_st.rdata = `VSA_RESET_WORD;
    next_st.store_pulse = clear_and_store;
    next_st.cmatch = vertical_clear_point && horizontal_clear_point;

    // stop wins when start and stop are equal
    if (vcount_i == vertical_stop_count) begin
      next_st.vact = 1'b0;
    end else if (vcount_i == vertical_start_count) begin
      next_st.vact = 1'b1;
    end

    // stop wins here too, giving an empty window
    if (hcount_i == horizontal_stop_count) begin
      next_st.hact = 1'b0;
    end else if (hcount_i == window_begin_count) begin
      next_st.hact = 1'b1;
    end

    if (clear_and_store) begin
      if (!grayscale_i || st.frame == `VSA_GRAY_LAST) begin
        next_st.frame = `VSA_FRAME_ZERO;
      end else begin
        next_st.frame = st.frame + `VSA_FRAME_ONE;
      end
      if (store_ok) begin
        // capture before the shift register clears
        next_st.result = sig.signature;
      end
    end

    if (wr_i) begin
      case (addr_i)
        `VSA_ADDR_CTRL: begin
          next_st.ctrl = wdata_i & `VSA_CTRL_MASK;
        end
        `VSA_ADDR_VWIN: begin
          next_st.vwin = wdata_i & `VSA_WIN_MASK;
        end
        `VSA_ADDR_HWIN: begin
          next_st.hwin = wdata_i & `VSA_WIN_MASK;
        end
        `VSA_ADDR_CLRPT: begin
          next_st.clrpt = wdata_i & `VSA_WIN_MASK;
        end
        `VSA_ADDR_STATUS: begin
          next_st.status = st.status & ~(wdata_i & `VSA_STAT_MASK);
        end
        `VSA_ADDR_MASK: begin
          next_st.mask = wdata_i & `VSA_STAT_MASK;
        end
        default: begin
          // result is read-only, unmapped writes are dropped
        end
      endcase
    end

    // events set after the clear so a same-cycle event wins
    if (clear_and_store) begin
      next_st.status[`VSA_IRQ_CLEAR] = 1'b1;
      if (store_ok) begin
        next_st.status[`VSA_IRQ_STORE] = 1'b1;
      end
    end

    if (rd_i) begin
      case (addr_i)
        `VSA_ADDR_RESULT: begin
          next_st.rdata = {16'h0000, st.result};
        end
        `VSA_ADDR_CTRL: begin
          next_st.rdata = st.ctrl;
        end
        `VSA_ADDR_VWIN: begin
          next_st.rdata = st.vwin;
        end
        `VSA_ADDR_HWIN: begin
          next_st.rdata = st.hwin;
        end
        `VSA_ADDR_CLRPT: begin
          next_st.rdata = st.clrpt;
        end
        `VSA_ADDR_STATUS: begin
          next_st.rdata = st.status;
        end
        `VSA_ADDR_MASK: begin
          next_st.rdata = st.mask;
        end
        default: begin
          next_st.rdata = `VSA_RESET_WORD;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rdata;
  // one-cycle pulse, suits an edge-triggered controller input
  assign clear_and_store_o = st.store_pulse;
  // level from flops only, no path from the bus inputs
  assign irq_o = |(st.status & st.mask);

  // checks
  a_enable_gate: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !enable |-> !sig.accumulate && !sig.clear)
    else $error("accumulate or clear while disabled");

  a_ctrl_select: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (st.ctrl[`VSA_CTRL_PIXEL_CLOCK_OUT_SELECT] == 1'b0) |-> (sig.data[`VSA_DATA_W-1] == 1'b0))
    else $error("deselected pixel clock reaches signature");

  a_pixel_select: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (sig.data[`VSA_PEN_W-1:0] & ~st.ctrl[`VSA_PEN_W-1:0]) == '0)
    else $error("deselected pixel bit reaches signature");

  a_vwin_start: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (vcount_i == vertical_start_count) && (vcount_i != vertical_stop_count) && !wr_i
    |=> st.vact)
    else $error("vertical window did not open");

  a_vwin_stop: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (vcount_i == vertical_stop_count) && !wr_i |=> !st.vact)
    else $error("vertical window did not close");

  a_hwin_start: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (hcount_i == window_begin_count) && (hcount_i != horizontal_stop_count) && !wr_i
    |=> st.hact)
    else $error("horizontal window did not open");

  a_hwin_stop: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (hcount_i == horizontal_stop_count) && !wr_i |=> !st.hact)
    else $error("horizontal window did not close");

  a_window_and: assert property (@(posedge clock_i) disable iff (!resetn_i)
    sig.accumulate |-> st.vact && st.hact)
    else $error("accumulate outside window");

  a_clear_point: assert property (@(posedge clock_i) disable iff (!resetn_i)
    enable && (vcount_i == vertical_clear_count) && (hcount_i == horizontal_clear_count)
    && !$past(vertical_clear_point && horizontal_clear_point) |-> sig.clear)
    else $error("clear point missed");

  a_clear_pixel: assert property (@(posedge clock_i) disable iff (!resetn_i)
    sig.clear |-> (hcount_i == horizontal_clear_count))
    else $error("clear at wrong pixel");

  a_store_result: assert property (@(posedge clock_i) disable iff (!resetn_i)
    sig.clear && store_ok |=> (st.result == $past(sig.signature))
    && (sig.signature == `VSA_RESET_SIG))
    else $error("result not stored at clear point");

  a_irq_pulse: assert property (@(posedge clock_i) disable iff (!resetn_i)
    sig.clear |=> clear_and_store_o ##1 !clear_and_store_o)
    else $error("secondary interrupt pulse wrong");

  a_result_low: assert property (@(posedge clock_i) disable iff (!resetn_i)
    rd_i && (addr_i == `VSA_ADDR_RESULT) |=> rdata_o == {16'h0000, $past(st.result)})
    else $error("result readback wrong");

  a_gray_hold: assert property (@(posedge clock_i) disable iff (!resetn_i)
    sig.clear && grayscale_i && (st.frame != `VSA_FRAME_ZERO) |=> $stable(st.result))
    else $error("grayscale result updated early");

  a_hold_off: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !enable |=> $stable(sig.signature))
    else $error("signature moved while disabled");

  c_accumulate: cover property (@(posedge clock_i) disable iff (!resetn_i)
    sig.accumulate ##1 sig.accumulate);
  c_store: cover property (@(posedge clock_i) disable iff (!resetn_i)
    sig.clear && store_ok && (sig.signature != '0));
  c_gray_skip: cover property (@(posedge clock_i) disable iff (!resetn_i)
    sig.clear && !store_ok);
  c_irq: cover property (@(posedge clock_i) disable iff (!resetn_i)
    $rose(irq_o));
endmodule

/* verif/testbench.sv */
// self-checking bench of the signature analyzer against a reference model
`timescale 1ns/1ps
`include "vsa_defines.svh"
module testbench;
  import vsa_pkg::*;
  logic clock_i = 1'b0;
  logic resetn_i, wr_i, rd_i, hold, gray, brightness_out_select, clkgate;
  logic pclk, blank, hsync, vsync, cs_o, irq_o;
  vsa_word_type addr_i, wdata_i, rdata_o;
  vsa_pixel_type pixel;
  vsa_count_type hcount, vcount;
  logic [31:0] seed = 32'h0000_8c1e;
  int n_fail = 0;
  int checked = 0;
  vsa_word_type ctrl_m, vwin_m, hwin_m, clr_m, stat_m, mask_m, erd;
  vsa_sig_type sig_m, res_m;
  logic vact_m, hact_m, pmatch, ecs, match, clr, st;
  logic [1:0] setb;
  logic [3:0] frame_m;

  vsa_top i_vsa_top (.clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pixel_i(pixel),
    .pixel_clock_level_i(pclk), .brightness_i(brightness_out_select), .clock_gate_i(clkgate),
    .blank_i(blank), .hsync_i(hsync), .vsync_i(vsync), .hcount_i(hcount),
    .vcount_i(vcount), .grayscale_i(gray), .clear_and_store_o(cs_o), .irq_o(irq_o));
  vsa_raster_model i_vsa_raster_model (.clock_i(clock_i), .resetn_i(resetn_i),
    .hold_i(hold), .hcount_o(hcount), .vcount_o(vcount), .pixel_clock_level_o(pclk),
    .blank_o(blank), .hsync_o(hsync), .vsync_o(vsync));

  always #4 clock_i = ~clock_i;

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic vsa_sig_type fold(input vsa_data_type d);
    vsa_sig_type f;
    f = '0;
    for (int i = 0; i < 30; i++) f[i % 16] ^= d[i];
    return f;
  endfunction

  task automatic check_word(input vsa_word_type e, input vsa_word_type g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic check_bit(input logic e, input logic g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic wr(input vsa_word_type a, input vsa_word_type d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input vsa_word_type a);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
  endtask

  task automatic frame(input int n);
    repeat (n * 160) @(posedge clock_i);
  endtask

  task automatic finish_test;
    $display("compares %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // random pixels and brightness/clock-gate levels every cycle
  always @(posedge clock_i) begin
    seed = lfsr_next(seed);
    pixel <= seed[23:0];
    brightness_out_select <= seed[24];
    clkgate <= seed[25];
  end

  // reference model: compares settled outputs, then steps one cycle
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {ctrl_m, vwin_m, hwin_m, clr_m, stat_m, mask_m, erd} = '0;
      {sig_m, res_m, vact_m, hact_m, pmatch, ecs, frame_m} = '0;
    end else begin
      check_word(erd, rdata_o);
      check_bit(ecs, cs_o);
      check_bit(|(stat_m & mask_m), irq_o);
      erd = '0;
      if (rd_i) case (addr_i)
        `VSA_ADDR_RESULT: erd = {16'h0000, res_m};
        `VSA_ADDR_CTRL: erd = ctrl_m;
        `VSA_ADDR_VWIN: erd = vwin_m;
        `VSA_ADDR_HWIN: erd = hwin_m;
        `VSA_ADDR_CLRPT: erd = clr_m;
        `VSA_ADDR_STATUS: erd = stat_m;
        `VSA_ADDR_MASK: erd = mask_m;
        default: erd = '0;
      endcase
      match = (vcount == clr_m[27:16]) && (hcount == clr_m[11:0]);
      clr = match && !pmatch && ctrl_m[31];
      ecs = clr;
      setb = 2'b00;
      if (clr) begin
        // store on every clear, or in grayscale only on every twelfth clear
        st = !gray || (frame_m == 4'h0);
        if (st) res_m = sig_m;
        sig_m = '0;
        setb = st ? 2'b11 : 2'b01;
        frame_m = !gray ? 4'h0 : ((frame_m == 4'hB) ? 4'h0 : frame_m + 4'h1);
      end else if (vact_m && hact_m && ctrl_m[31]) begin
        sig_m = {sig_m[14:0], ^(sig_m & `VSA_SIG_TAPS)} ^ fold({ctrl_m[29:24] &
          {pclk, brightness_out_select, clkgate, blank, hsync, vsync}, pixel & ctrl_m[23:0]});
      end
      pmatch = match;
      vact_m = (vcount == vwin_m[27:16]) ? 1'b0 : (vcount == vwin_m[11:0]) ? 1'b1 : vact_m;
      hact_m = (hcount == hwin_m[27:16]) ? 1'b0 : (hcount == hwin_m[11:0]) ? 1'b1 : hact_m;
      if (wr_i) case (addr_i)
        `VSA_ADDR_CTRL: ctrl_m = wdata_i & `VSA_CTRL_MASK;
        `VSA_ADDR_VWIN: vwin_m = wdata_i & `VSA_WIN_MASK;
        `VSA_ADDR_HWIN: hwin_m = wdata_i & `VSA_WIN_MASK;
        `VSA_ADDR_CLRPT: clr_m = wdata_i & `VSA_WIN_MASK;
        `VSA_ADDR_STATUS: stat_m = stat_m & ~wdata_i;
        `VSA_ADDR_MASK: mask_m = wdata_i & `VSA_STAT_MASK;
        default: ;
      endcase
      stat_m = stat_m | {30'h0000_0000, setb};
    end
  end

  initial begin
    repeat (20000) @(posedge clock_i);
    n_fail++;
    finish_test();
  end

  initial begin
    resetn_i = 1'b0;
    {wr_i, rd_i, hold, gray} = 4'h0;
    {addr_i, wdata_i} = '0;
    repeat (4) @(posedge clock_i);
    resetn_i <= 1'b1;
    // reset values, unmapped word, read-only result, reserved bits
    for (int i = 0; i < 8; i++) rd(32'h8003_0200 + 32'(4 * i));
    for (int i = 0; i < 8; i++) wr(32'h8003_0200 + 32'(4 * i), 32'hFFFF_FFFF);
    for (int i = 0; i < 8; i++) rd(32'h8003_0200 + 32'(4 * i));
    wr(`VSA_ADDR_VWIN, 32'h0001_0008);
    wr(`VSA_ADDR_HWIN, 32'h0002_000D);
    wr(`VSA_ADDR_CLRPT, 32'h0002_0003);
    for (int b = 24; b < 30; b++) begin
      wr(`VSA_ADDR_CTRL, 32'h8000_0000 | (32'h0000_0001 << b));
      frame(1);
      rd(`VSA_ADDR_RESULT);
    end
    // random pixel selects, interrupt raised, masked, cleared
    wr(`VSA_ADDR_CTRL, 32'hBF00_0000 | {8'h00, seed[23:0]});
    frame(2);
    rd(`VSA_ADDR_STATUS);
    wr(`VSA_ADDR_MASK, 32'h0000_0000);
    rd(`VSA_ADDR_RESULT);
    wr(`VSA_ADDR_STATUS, 32'h0000_0001);
    wr(`VSA_ADDR_MASK, 32'h0000_0002);
    wr(`VSA_ADDR_STATUS, 32'h0000_0002);
    // start equal to stop keeps the window shut
    wr(`VSA_ADDR_VWIN, 32'h0005_0005);
    frame(1);
    wr(`VSA_ADDR_VWIN, 32'h0001_0008);
    wr(`VSA_ADDR_CTRL, 32'h3FFF_FFFF);
    frame(1);
    rd(`VSA_ADDR_STATUS);
    // a parked raster gives a single clear
    wr(`VSA_ADDR_CTRL, 32'hBFFF_FFFF);
    for (int k = 0; k < 400 && !(vcount == 12'h002 && hcount == 12'h004); k++)
      @(posedge clock_i);
    hold <= 1'b1;
    repeat (6) @(posedge clock_i);
    hold <= 1'b0;
    // grayscale stores on the first and thirteenth clear only
    gray <= 1'b1;
    for (int f = 0; f < 13; f++) begin
      frame(1);
      rd(`VSA_ADDR_RESULT);
    end
    gray <= 1'b0;
    frame(1);
    // reset again mid-frame
    resetn_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    rd(`VSA_ADDR_RESULT);
    rd(`VSA_ADDR_CTRL);
    frame(1);
    finish_test();
  end
endmodule

/* verif/vsa_raster_model.sv */
// raster engine stand-in: down counters and video control outputs
`timescale 1ns/1ps
module vsa_raster_model #(
  parameter int H_TOP = 15,
  parameter int V_TOP = 9
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic hold_i,
  output vsa_pkg::vsa_count_type hcount_o,
  output vsa_pkg::vsa_count_type vcount_o,
  output logic pixel_clock_level_o,
  output logic blank_o,
  output logic hsync_o,
  output logic vsync_o
);
  import vsa_pkg::*;

  // hold freezes the raster so a slow engine parks on one position
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hcount_o <= vsa_count_type'(H_TOP);
      vcount_o <= vsa_count_type'(V_TOP);
    end else if (!hold_i) begin
      if (hcount_o == 0) begin
        hcount_o <= vsa_count_type'(H_TOP);
        vcount_o <= (vcount_o == 0) ? vsa_count_type'(V_TOP) : vcount_o - 12'h001;
      end else begin
        hcount_o <= hcount_o - 12'h001;
      end
    end
  end

  assign pixel_clock_level_o = hcount_o[0];
  assign blank_o = (hcount_o > 12);
  assign hsync_o = (hcount_o < 2);
  assign vsync_o = (vcount_o == 0);
endmodule
